// ===== src/cesp_counter.sv
// Top of one counter: edge-separation measurement and pulse generation.
`timescale 1ns/1ps

// What this block does
// - Aux edge starts, gate edge stops counting
// - Count source edges, ignore extra aux
// - Gate edge stops count; pushes it except in sample mode
// - Aux and gate polarity independently selectable
// - Single mode ignores edges until re-armed
// - Implicit mode stores each interval, restarts
// - Sample mode pushes count on sample edge
// - Overrun when sample interval lacks pair
// - Single pulse: delay then width in ticks
// - Triggered pulse delay counts from trigger
// - Embedded counter stops finite train
// - Each trigger launches; delay-every option
// - Ignore gate while generating, then wait
// - Continuous train starts on arm or trigger
// - Separate high and low widths
// - Pause trigger halts and resumes generation
// - Frequency equals source over high plus low
// - Buffered trains take specs from FIFO
// - Sample-clocked uses default until first sample
// - Counter is thirty-two bits wide
module cesp_counter #(
  parameter int WIDTH = cesp_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // External signals
  input  wire logic             sourcePin,
  input  wire logic             auxPin,
  input  wire logic             gatePin,
  input  wire logic             samplePin,
  // Configuration
  input  wire logic [3:0]       mode,
  input  wire logic             arm,
  input  wire logic             sourceFall,
  input  wire logic             auxFall,
  input  wire logic             gateFall,
  input  wire logic             sampleFall,
  input  wire logic             gateStart,
  input  wire logic             gatePause,
  input  wire logic             pauseActiveLow,
  input  wire logic             retrigger,
  input  wire logic             delay_every_retrigger,
  input  wire logic [WIDTH-1:0] initDelay,
  input  wire logic [WIDTH-1:0] highTicks,
  input  wire logic [WIDTH-1:0] lowTicks,
  input  wire logic [WIDTH-1:0] pulseCount,
  // Result stream out
  output logic                  resValid,
  input  wire logic             resReady,
  output logic [WIDTH-1:0]      resData,
  // Pulse specification stream in
  input  wire logic             specValid,
  output logic                  specReady,
  input  wire logic [WIDTH-1:0] specIdle,
  input  wire logic [WIDTH-1:0] specActive,
  // Status
  output logic                  pulseOut,
  output logic                  overrun,
  output logic                  running,
  output logic                  finished
);
  import cesp_pkg::*;

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  logic srcEdge, auxEdge, gateEdge, sampEdge, gateLevel;

  cesp_sync uSrc (.clk(clk), .nrst(nrst), .pinIn(sourcePin), .fallSel(sourceFall),
                  .level(), .activeEdge(srcEdge));
  cesp_sync uAux (.clk(clk), .nrst(nrst), .pinIn(auxPin), .fallSel(auxFall),
                  .level(), .activeEdge(auxEdge));
  cesp_sync uGate (.clk(clk), .nrst(nrst), .pinIn(gatePin), .fallSel(gateFall),
                   .level(gateLevel), .activeEdge(gateEdge));
  cesp_sync uSamp (.clk(clk), .nrst(nrst), .pinIn(samplePin), .fallSel(sampleFall),
                   .level(), .activeEdge(sampEdge));

  logic armed_q, armPrev_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed_q   <= 1'b0;
      armPrev_q <= 1'b0;
    end else begin
      armed_q   <= arm;
      armPrev_q <= armed_q;
    end
  end
  wire logic armRise = armed_q & ~armPrev_q;

  wire logic isSep   = (mode == MODE_SEP_SINGLE) || (mode == MODE_SEP_IMPLICIT)
                     || (mode == MODE_SEP_SAMPLED);
  wire logic pauseOn = gatePause & ~gateStart & ~retrigger
                     & (gateLevel ^ pauseActiveLow);
  wire logic tick    = srcEdge & ~pauseOn;

  // ----------------------------------------------------------------
  // Edge-separation measurement
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CESP_S_WAIT, CESP_S_COUNT, CESP_S_HOLD} cesp_sstate_t;
  cesp_sstate_t     sep_q;
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] latched_q;
  logic             latchedFull_q;
  logic             pairSeen_q;
  logic             sepPush;
  logic [WIDTH-1:0] sepPushData;

  wire logic sepStop = (sep_q == CESP_S_COUNT) && gateEdge;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sep_q   <= CESP_S_WAIT;
      count_q <= CNT_ZERO;
    end else if (!armed_q || !isSep) begin
      sep_q   <= CESP_S_WAIT;
      count_q <= CNT_ZERO;
    end else begin
      unique case (sep_q)
        CESP_S_WAIT: begin
          if (auxEdge) begin
            sep_q   <= CESP_S_COUNT;
            count_q <= CNT_ZERO;
          end
        end
        CESP_S_COUNT: begin
          if (gateEdge) begin
            sep_q <= (mode == MODE_SEP_SINGLE) ? CESP_S_HOLD : CESP_S_WAIT;
          end else if (srcEdge) begin
            count_q <= count_q + CNT_ONE;
          end
        end
        CESP_S_HOLD: begin
          sep_q <= CESP_S_HOLD;
        end
      endcase
    end
  end

  // Sample-clocked mode parks the finished count until the sample edge.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latched_q     <= CNT_ZERO;
      latchedFull_q <= 1'b0;
      pairSeen_q    <= 1'b0;
      overrun       <= 1'b0;
    end else if (!armed_q || mode != MODE_SEP_SAMPLED) begin
      latchedFull_q <= 1'b0;
      pairSeen_q    <= 1'b0;
      if (armRise) begin
        overrun <= 1'b0;
      end
    end else begin
      if (armRise) begin
        overrun <= 1'b0;
      end
      if (sepStop) begin
        latched_q     <= count_q;
        latchedFull_q <= 1'b1;
      end else if (sampEdge) begin
        latchedFull_q <= 1'b0;
      end
      if (sepStop) begin
        pairSeen_q <= 1'b1;
      end else if (sampEdge) begin
        pairSeen_q <= 1'b0;
      end
      if (sampEdge && !pairSeen_q) begin
        overrun <= 1'b1;
      end
    end
  end

  always_comb begin
    sepPush     = 1'b0;
    sepPushData = count_q;
    if (armed_q && sepStop && mode != MODE_SEP_SAMPLED) begin
      sepPush = 1'b1;
    end else if (armed_q && mode == MODE_SEP_SAMPLED && sampEdge && pairSeen_q) begin
      sepPush     = 1'b1;
      sepPushData = latchedFull_q ? latched_q : count_q;
    end
  end

  // One-entry output register; single mode stays in hold after software has taken it, until disarmed.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resValid <= 1'b0;
      resData  <= CNT_ZERO;
    end else if (!armed_q) begin
      resValid <= 1'b0;
    end else if (sepPush) begin
      resValid <= 1'b1;
      resData  <= sepPushData;
    end else if (resReady) begin
      resValid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pulse generation
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {CESP_G_IDLE, CESP_G_TRIG, CESP_G_RUN, CESP_G_DONE} cesp_gstate_t;
  cesp_gstate_t     gen_q;
  logic [WIDTH-1:0] pulses_q;
  logic             firstDone_q;
  logic             sampled_q;
  logic [WIDTH-1:0] curIdle_q;
  logic [WIDTH-1:0] curActive_q;
  logic             launch;
  logic [WIDTH-1:0] launchIdle, launchActive;
  logic             tBusy, tDone, tOut;

  wire logic isGen    = !isSep && armed_q;
  wire logic trigMode = (mode == MODE_PULSE_TRIG) || gateStart || retrigger;
  wire logic oneShot  = (mode == MODE_PULSE) || (mode == MODE_PULSE_TRIG);
  wire logic useDelay = !firstDone_q && !tDone;
  wire logic trainEnd = (mode == MODE_TRAIN_FINITE) && (pulses_q + CNT_ONE >= pulseCount);
  // The timer is idle in the cycle its last pulse ends; no new pulse may start then.
  wire logic lastDone = tDone && (oneShot || trainEnd);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gen_q       <= CESP_G_IDLE;
      pulses_q    <= CNT_ZERO;
      firstDone_q <= 1'b0;
    end else if (!isGen) begin
      gen_q       <= CESP_G_IDLE;
      pulses_q    <= CNT_ZERO;
      firstDone_q <= 1'b0;
    end else begin
      unique case (gen_q)
        CESP_G_IDLE: begin
          gen_q <= trigMode ? CESP_G_TRIG : CESP_G_RUN;
        end
        CESP_G_TRIG: begin
          if (gateEdge) begin
            gen_q    <= CESP_G_RUN;
            pulses_q <= CNT_ZERO;
            if (retrigger && delay_every_retrigger) begin
              firstDone_q <= 1'b0;
            end
          end
        end
        CESP_G_RUN: begin
          if (tDone) begin
            firstDone_q <= 1'b1;
            pulses_q    <= pulses_q + CNT_ONE;
            if (oneShot || trainEnd) begin
              gen_q <= retrigger ? CESP_G_TRIG : CESP_G_DONE;
            end
          end
        end
        CESP_G_DONE: begin
          gen_q <= CESP_G_DONE;
        end
      endcase
    end
  end

  // Buffered sample-clocked trains adopt a FIFO spec only at a sample edge.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sampled_q   <= 1'b0;
      curIdle_q   <= CNT_ZERO;
      curActive_q <= CNT_ZERO;
    end else if (!isGen) begin
      sampled_q <= 1'b0;
    end else if (mode == MODE_BUF_SAMPLED && sampEdge && specValid) begin
      sampled_q   <= 1'b1;
      curIdle_q   <= specIdle;
      curActive_q <= specActive;
    end
  end

  always_comb begin
    launch       = 1'b0;
    launchIdle   = lowTicks;
    launchActive = highTicks;
    specReady    = 1'b0;
    if (isGen && gen_q == CESP_G_RUN && !tBusy && !lastDone) begin
      launch = 1'b1;
      if (mode == MODE_BUF_IMPLICIT) begin
        launch       = specValid;
        specReady    = 1'b1;
        launchIdle   = specIdle;
        launchActive = specActive;
      end else if (mode == MODE_BUF_SAMPLED && sampled_q) begin
        launchIdle   = curIdle_q;
        launchActive = curActive_q;
      end
      if (useDelay && mode != MODE_BUF_IMPLICIT) begin
        launchIdle = initDelay;
      end
    end
    if (mode == MODE_BUF_SAMPLED && isGen) begin
      specReady = sampEdge;
    end
  end

  cesp_pulse_timer #(.WIDTH(WIDTH)) uTimer (
    .clk(clk), .nrst(nrst), .launch(launch), .abort(!isGen), .tick(tick),
    .idleTicks(launchIdle), .activeTicks(launchActive),
    .pulseOut(tOut), .busy(tBusy), .done(tDone)
  );

  assign pulseOut = tOut;
  assign running  = (sep_q == CESP_S_COUNT) || tBusy;
  assign finished = (sep_q == CESP_S_HOLD) || (gen_q == CESP_G_DONE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  start_on_aux_a: assert property (armed_q && isSep && sep_q == CESP_S_WAIT && auxEdge
    |=> sep_q == CESP_S_COUNT) else $error("Aux edge did not start count");
  count_inc_a: assert property (sep_q == CESP_S_COUNT && srcEdge && !gateEdge && armed_q
    && isSep |=> count_q == $past(count_q) + CNT_ONE) else $error("Count missed edge");
  push_on_gate_a: assert property (armed_q && sepStop && mode == MODE_SEP_IMPLICIT
    |=> resValid && resData == $past(count_q)) else $error("Count not pushed");
  single_hold_a: assert property (sep_q == CESP_S_HOLD && armed_q && isSep
    |=> sep_q == CESP_S_HOLD) else $error("Single mode left hold");
  overrun_set_a: assert property (armed_q && mode == MODE_SEP_SAMPLED && sampEdge
    && !pairSeen_q |=> overrun) else $error("Overrun not flagged");
  sample_push_a: assert property (armed_q && mode == MODE_SEP_SAMPLED && sepStop
    && !sampEdge |-> !sepPush) else $error("Sampled count pushed early");
  disarm_idle_a: assert property (!armed_q |=> ##1 !pulseOut)
    else $error("Output active after disarm");
  pause_hold_a: assert property (pauseOn |-> !tick)
    else $error("Tick passed during pause");
  retrig_ignore_a: assert property (gen_q == CESP_G_RUN && gateEdge && !tDone && isGen
    |=> gen_q == CESP_G_RUN) else $error("Gate acted during pulse");

  sep_done_c: cover property (sepPush);
  pulse_c: cover property (tDone);
  overrun_c: cover property ($rose(overrun));
  finite_c: cover property (gen_q == CESP_G_RUN ##1 gen_q == CESP_G_DONE);

endmodule : cesp_counter

// ===== include/cesp_pkg.sv
// Package of modes, widths and constants for the counter edge-separation and pulse block.
package cesp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W     = 32;
  localparam int SYNC_LEN  = 3;
  localparam int MIN_TRIG_TICKS = 2;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_SEP_SINGLE   = 4'h0;
  localparam logic [3:0] MODE_SEP_IMPLICIT = 4'h1;
  localparam logic [3:0] MODE_SEP_SAMPLED  = 4'h2;
  localparam logic [3:0] MODE_PULSE        = 4'h3;
  localparam logic [3:0] MODE_PULSE_TRIG   = 4'h4;
  localparam logic [3:0] MODE_TRAIN_FINITE = 4'h5;
  localparam logic [3:0] MODE_TRAIN_CONT   = 4'h6;
  localparam logic [3:0] MODE_BUF_IMPLICIT = 4'h7;
  localparam logic [3:0] MODE_BUF_SAMPLED  = 4'h8;

  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;

endpackage : cesp_pkg

// ===== src/cesp_sync.sv
// Three-stage synchroniser with agreement-based change and polarity edge detect.
`timescale 1ns/1ps
module cesp_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Pin and edge selection
  input  wire logic pinIn,
  input  wire logic fallSel,
  // Result
  output logic      level,
  output logic      activeEdge
);
  import cesp_pkg::*;

  logic [SYNC_LEN-1:0] stage_q;
  logic                level_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[SYNC_LEN-2:0], pinIn};
    end
  end

  // A change counts once the second and third stages agree.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level_q <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      level_q <= stage_q[2];
    end
  end

  wire logic agreed = (stage_q[1] == stage_q[2]) ? stage_q[2] : level_q;

  assign level      = level_q;
  assign activeEdge = fallSel ? (level_q & ~agreed) : (~level_q & agreed);

endmodule : cesp_sync

// ===== src/cesp_pulse_timer.sv
// Pulse shaper that times idle then active phases in source ticks.
`timescale 1ns/1ps
module cesp_pulse_timer #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Control
  input  wire logic             launch,
  input  wire logic             abort,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] idleTicks,
  input  wire logic [WIDTH-1:0] activeTicks,
  // Status
  output logic                  pulseOut,
  output logic                  busy,
  output logic                  done
);
  import cesp_pkg::*;

  typedef enum logic [1:0] {CESP_T_IDLE, CESP_T_WAIT, CESP_T_HIGH} cesp_tstate_t;
  cesp_tstate_t      state_q;
  logic [WIDTH-1:0]  cnt_q;
  logic [WIDTH-1:0]  activeHold_q;

  // A phase of zero ticks is taken as one tick so the timer always advances.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q      <= CESP_T_IDLE;
      cnt_q        <= '0;
      activeHold_q <= '0;
      done         <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        state_q <= CESP_T_IDLE;
      end else begin
        unique case (state_q)
          CESP_T_IDLE: begin
            if (launch) begin
              state_q      <= CESP_T_WAIT;
              cnt_q        <= idleTicks;
              activeHold_q <= activeTicks;
            end
          end
          CESP_T_WAIT: begin
            if (tick) begin
              if (cnt_q <= WIDTH'(1)) begin
                state_q <= CESP_T_HIGH;
                cnt_q   <= activeHold_q;
              end else begin
                cnt_q <= cnt_q - WIDTH'(1);
              end
            end
          end
          CESP_T_HIGH: begin
            if (tick) begin
              if (cnt_q <= WIDTH'(1)) begin
                state_q <= CESP_T_IDLE;
                done    <= 1'b1;
              end else begin
                cnt_q <= cnt_q - WIDTH'(1);
              end
            end
          end
        endcase
      end
    end
  end

  assign pulseOut = (state_q == CESP_T_HIGH);
  assign busy     = (state_q != CESP_T_IDLE);

endmodule : cesp_pulse_timer

// ===== test/cesp_far_model.sv
// Far-side model: a free-running count source and the aux, gate and sample pins.
`timescale 1ns/1ps
module cesp_far_model (
  // Clock
  input  wire logic clk,
  // Pins toward the counter
  output logic      sourcePin,
  output logic      auxPin,
  output logic      gatePin,
  output logic      samplePin
);
  logic [2:0] pinQ   = 3'h0;
  logic [3:0] srcDiv = 4'h0;

  // ----------------------------------------------------------------
  // Count source
  // ----------------------------------------------------------------
  // The source has a ten-cycle period, so the other pins can move mid-period.
  always @(posedge clk) begin
    srcDiv <= (srcDiv == 4'h9) ? 4'h0 : srcDiv + 4'h1;
  end

  assign sourcePin = (srcDiv < 4'h5);
  assign auxPin    = pinQ[0];
  assign gatePin   = pinQ[1];
  assign samplePin = pinQ[2];

  // ----------------------------------------------------------------
  // Pin moves
  // ----------------------------------------------------------------
  task automatic align();
    @(posedge sourcePin);
    repeat (2) @(posedge clk);
    #1;
  endtask : align

  task automatic set(input int which, input logic lvl);
    pinQ[which] = lvl;
  endtask : set

  task automatic edgeAt(input int which, input logic lvl, input int n);
    repeat (n) align();
    set(which, lvl);
  endtask : edgeAt

  // The pin is held active for a whole source period so the counter cannot miss it.
  task automatic strike(input int which, input logic fall, input int n);
    edgeAt(which, ~fall, n);
    edgeAt(which, fall, 1);
  endtask : strike
endmodule : cesp_far_model

// ===== test/tb.sv
// Self-checking bench for one counter in its edge-separation, pulse and train modes.
`timescale 1ns/1ps
module tb;
  import cesp_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic             clk = 1'b0, nrst = 1'b0, arm = 1'b0;
  logic             sourcePin, auxPin, gatePin, samplePin;
  logic [3:0]       mode = MODE_SEP_SINGLE;
  logic             sourceFall = 1'b0, auxFall = 1'b0, gateFall = 1'b0, sampleFall = 1'b0;
  logic             gateStart = 1'b0, gatePause = 1'b0, pauseActiveLow = 1'b0;
  logic             retrigger = 1'b0, delay_every_retrigger = 1'b0;
  logic [CNT_W-1:0] initDelay = 32'h0, highTicks = 32'h0, lowTicks = 32'h0, pulseCount = 32'h0;
  logic             resReady = 1'b0, specValid = 1'b0;
  logic [CNT_W-1:0] specIdle = 32'h0, specActive = 32'h0, resData;
  logic             resValid, specReady, pulseOut, overrun, running, finished, lvl;
  int               failures = 0, n_tests = 0, d, w, ch;
  int               si[3] = '{2, 3, 2};
  int               sa[3] = '{2, 4, 2};

  cesp_far_model farU (.clk(clk), .sourcePin(sourcePin), .auxPin(auxPin), .gatePin(gatePin),
    .samplePin(samplePin));

  cesp_counter dut_u (.clk(clk), .nrst(nrst), .sourcePin(sourcePin), .auxPin(auxPin),
    .gatePin(gatePin), .samplePin(samplePin), .mode(mode), .arm(arm),
    .sourceFall(sourceFall), .auxFall(auxFall), .gateFall(gateFall), .sampleFall(sampleFall),
    .gateStart(gateStart), .gatePause(gatePause), .pauseActiveLow(pauseActiveLow),
    .retrigger(retrigger), .delay_every_retrigger(delay_every_retrigger),
    .initDelay(initDelay), .highTicks(highTicks), .lowTicks(lowTicks),
    .pulseCount(pulseCount), .resValid(resValid), .resReady(resReady), .resData(resData),
    .specValid(specValid), .specReady(specReady), .specIdle(specIdle),
    .specActive(specActive), .pulseOut(pulseOut), .overrun(overrun), .running(running),
    .finished(finished));

  initial forever #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic lost(input string what);
    chk(what, 1, 0);
    test_done();
  endtask : lost

  task automatic stop();
    arm = 1'b0;
    tick(4);
  endtask : stop

  task automatic start(input logic [3:0] m);
    mode = m;
    farU.align();
    arm = 1'b1;
  endtask : start

  // Counts source rises before the next pulse and during it; d is -1 if none ends.
  task automatic watch(input int lim, output int dd, output int ww);
    logic prev;
    int   ph;
    dd = 0;
    ww = 0;
    ph = 0;
    prev = sourcePin;
    for (int i = 0; i < lim && ph < 2; i++) begin
      tick(1);
      if (ph == 0 && pulseOut === 1'b1) ph = 1;
      else if (ph == 1 && pulseOut !== 1'b1) ph = 2;
      if (sourcePin && !prev) begin
        if (ph == 0) dd++;
        else if (ph == 1) ww++;
      end
      prev = sourcePin;
    end
    if (ph < 2) dd = -1;
  endtask : watch

  task automatic getRes(input int exp);
    int k;
    k = 0;
    while (resValid !== 1'b1 && k < 400) begin
      tick(1);
      k++;
    end
    if (k == 400) lost("result wait");
    chk("resData", exp, resData);
    resReady = 1'b1;
    tick(1);
    resReady = 1'b0;
  endtask : getRes

  task automatic putSpec(input int i, input int a);
    int k;
    k = 0;
    specIdle = i;
    specActive = a;
    specValid = 1'b1;
    while (specReady !== 1'b1 && k < 2000) begin
      tick(1);
      k++;
    end
    if (k == 2000) lost("spec wait");
    tick(1);
  endtask : putSpec

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    tick(5);
    nrst = 1'b1;
    tick(2);
    chk("result width", 32, $bits(resData));
    for (int p = 0; p < 4; p++) begin
      stop();
      auxFall = p[0];
      gateFall = p[1];
      farU.set(0, p[0]);
      farU.set(1, p[1]);
      farU.strike(0, p[0], 1);
      start(MODE_SEP_SINGLE);
      farU.strike(1, p[1], 3);
      tick(30);
      chk("early result", 0, resValid);
      farU.strike(0, p[0], 1);
      farU.strike(0, p[0], 1);
      farU.strike(1, p[1], 3);
      getRes(6);
      farU.strike(0, p[0], 1);
      farU.strike(1, p[1], 2);
      tick(30);
      chk("late result", 0, resValid);
    end
    stop();
    auxFall = 1'b0;
    gateFall = 1'b0;
    farU.set(0, 1'b0);
    farU.set(1, 1'b0);
    start(MODE_SEP_IMPLICIT);
    for (int n = 2; n < 5; n++) begin
      farU.strike(0, 1'b0, 1);
      farU.strike(1, 1'b0, n - 1);
      getRes(n);
    end
    stop();
    start(MODE_SEP_SAMPLED);
    farU.strike(0, 1'b0, 1);
    farU.strike(1, 1'b0, 3);
    tick(40);
    chk("held result", 0, resValid);
    farU.strike(2, 1'b0, 1);
    getRes(4);
    chk("overrun", 0, overrun);
    farU.strike(2, 1'b0, 1);
    tick(20);
    chk("overrun", 1, overrun);
    stop();
    initDelay = 32'h4;
    highTicks = 32'h3;
    lowTicks = 32'h2;
    start(MODE_PULSE);
    watch(400, d, w);
    chk("delay", 4, d);
    chk("width", 3, w);
    chk("overrun cleared", 0, overrun);
    watch(300, d, w);
    chk("extra pulse", -1, d);
    // Pause stays off while retriggering, and the delay leaves the trigger room.
    gateStart = 1'b1;
    initDelay = 32'h5;
    retrigger = 1'b1;
    for (int e = 1; e >= 0; e--) begin
      stop();
      delay_every_retrigger = e[0];
      farU.set(1, 1'b0);
      start(MODE_PULSE_TRIG);
      watch(150, d, w);
      chk("untriggered", -1, d);
      farU.edgeAt(1, 1'b1, 1);
      fork
        watch(400, d, w);
        begin
          farU.edgeAt(1, 1'b0, 3);
          farU.edgeAt(1, 1'b1, 1);
        end
      join
      chk("trig delay", 5, d);
      chk("trig width", 3, w);
      watch(200, d, w);
      chk("ignored trigger", -1, d);
      farU.edgeAt(1, 1'b0, 1);
      farU.edgeAt(1, 1'b1, 1);
      watch(400, d, w);
      chk("retrig delay", e ? 5 : 2, d);
    end
    stop();
    retrigger = 1'b0;
    gateStart = 1'b0;
    farU.set(1, 1'b0);
    initDelay = 32'h2;
    highTicks = 32'h2;
    lowTicks = 32'h3;
    pulseCount = 32'h3;
    start(MODE_TRAIN_FINITE);
    for (int k = 0; k < 3; k++) begin
      watch(400, d, w);
      chk("train gap", k == 0 ? 2 : 3, d);
      chk("train width", 2, w);
    end
    watch(300, d, w);
    chk("train end", -1, d);
    chk("finished", 1, finished);
    stop();
    gatePause = 1'b1;
    start(MODE_TRAIN_CONT);
    for (int k = 0; k < 3; k++) begin
      watch(400, d, w);
      chk("cont gap", k == 0 ? 2 : 3, d);
      chk("cont width", 2, w);
    end
    farU.edgeAt(1, 1'b1, 1);
    tick(10);
    lvl = pulseOut;
    ch = 0;
    for (int k = 0; k < 200; k++) begin
      tick(1);
      if (pulseOut !== lvl) ch++;
    end
    chk("paused output", 0, ch);
    farU.set(1, 1'b0);
    watch(400, d, w);
    chk("resumed", 1, d >= 0);
    for (int k = 0; k < 200 && pulseOut !== 1'b1; k++) tick(1);
    if (pulseOut !== 1'b1) lost("pulse wait");
    stop();
    chk("disarmed output", 0, pulseOut);
    chk("disarmed running", 0, running);
    tick(100);
    chk("disarmed output", 0, pulseOut);
    gatePause = 1'b0;
    initDelay = 32'h9;
    highTicks = 32'h9;
    start(MODE_BUF_IMPLICIT);
    fork
      begin
        for (int k = 0; k < 3; k++) putSpec(si[k], sa[k]);
        specValid = 1'b0;
      end
      for (int k = 0; k < 3; k++) begin
        watch(400, d, w);
        chk("spec idle", si[k], d);
        chk("spec active", sa[k], w);
      end
    join
    stop();
    specIdle = 32'h3;
    specActive = 32'h2;
    specValid = 1'b1;
    start(MODE_BUF_SAMPLED);
    watch(400, d, w);
    chk("default idle", 9, d);
    chk("default active", 9, w);
    farU.strike(2, 1'b0, 1);
    watch(400, d, w);
    watch(400, d, w);
    chk("sampled idle", 3, d);
    chk("sampled active", 2, w);
    specValid = 1'b0;
    stop();
    test_done();
  end
endmodule : tb
